/* hdl/e1sa_pkg.sv */
// ****************************************************************
// constants and carriers for the multiframe Si/A/Sa register bank
// ****************************************************************
package e1sa_pkg;

    // register offsets on the parallel port
    localparam logic [7:0] E1SA_RX_SPARE5_OFS  = 8'hCC;
    localparam logic [7:0] E1SA_RX_SPARE6_OFS  = 8'hCD;
    localparam logic [7:0] E1SA_RX_SPARE7_OFS  = 8'hCE;
    localparam logic [7:0] E1SA_RX_SPARE8_OFS  = 8'hCF;
    localparam logic [7:0] E1SA_TX_SI_AL_OFS   = 8'hD2;
    localparam logic [7:0] E1SA_TX_SI_NAL_OFS  = 8'hD3;
    localparam logic [7:0] E1SA_TX_RA_OFS      = 8'hD4;
    localparam logic [7:0] E1SA_TX_SPARE4_OFS  = 8'hD5;
    localparam logic [7:0] E1SA_TX_SPARE5_OFS  = 8'hD6;
    localparam logic [7:0] E1SA_TX_SPARE6_OFS  = 8'hD7;
    localparam logic [7:0] E1SA_TX_SPARE7_OFS  = 8'hD8;
    localparam logic [7:0] E1SA_TX_SPARE8_OFS  = 8'hD9;
    localparam logic [7:0] E1SA_TX_CTRL_OFS    = 8'hDA;

    // every register clears to this value
    localparam logic [7:0] E1SA_REG_RESET      = 8'h00;
    // unmapped reads return this value
    localparam logic [7:0] E1SA_READ_NONE      = 8'h00;

    // insertion-control field positions; bits 4..0 pick Sa4..Sa8
    localparam int unsigned E1SA_CTRL_SA_MSB   = 4;
    localparam int unsigned E1SA_CTRL_RA_BIT   = 5;
    localparam int unsigned E1SA_CTRL_INSERT_INTL_NONALIGN_ENABLE    = 6;
    localparam int unsigned E1SA_CTRL_INSERT_INTL_ALIGN_ENABLE     = 7;

    // overhead bits of one frame; sa[4] is Sa4 down to sa[0] is Sa8
    typedef struct packed {
        logic       si;
        logic       a;
        logic [4:0] sa;
    } e1sa_ovh_type;

    // one multiframe worth of transmit data; sa[4] is Sa4 .. sa[0] Sa8
    typedef struct packed {
        logic [7:0]      si_align;
        logic [7:0]      si_nonalign;
        logic [7:0]      ra;
        logic [4:0][7:0] sa;
    } e1sa_txset_type;

    // bit slot of a frame: frames 0/1 sit in bit 7, frames 14/15 in bit 0
    function automatic logic [2:0] e1sa_frame_bit(input logic [3:0] frame);
        return 3'h7 - frame[3:1];
    endfunction

endpackage

/* hdl/e1sa_regs.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - receive Sa5-Sa8 odd frames, frame1 in bit7
// - align Si register: frame0 bit7, frame14 bit0
// - nonalign Si register: frame1 bit7, frame15 bit0
// - remote-alarm register: odd frames, frame1 bit7
// - transmit Sa4-Sa8 registers: frame1 bit7 down
// - control bits 0..4 insert Sa8..Sa4
// - control bit 5 inserts remote alarm
// - control bit 6 inserts nonalign Si
// - control bit 7 inserts align Si
// - receive registers update on receive multiframe flag
// - transmit registers sampled on transmit multiframe flag
// - transmit MSB is first bit sent
// - receive MSB is first bit received
module e1sa_regs (
    input  wire logic                   clk_i,
    input  wire logic                   reset_i,
    input  wire logic                   ce_i,
    input  wire logic [7:0]             addr_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    input  wire logic [7:0]             wdata_i,
    output logic [7:0]                  rdata_o,
    input  wire logic                   rx_multiframe_flag_i,
    input  wire logic                   rx_odd_strobe_i,
    input  wire logic [3:0]             rx_frame_i,
    input  wire logic [3:0]             rx_sa_i,
    input  wire logic                   tx_multiframe_flag_i,
    input  wire logic                   tx_frame_strobe_i,
    input  wire logic [3:0]             tx_frame_i,
    input  wire e1sa_pkg::e1sa_ovh_type tx_src_i,
    output e1sa_pkg::e1sa_ovh_type      tx_ovh_o,
    output logic                        tx_ovh_valid_o
);
    // ************************************************************
    // storage
    // ************************************************************
    logic [3:0][7:0]          rx_acc_q;   // bits gathered so far; [3]=Sa5 .. [0]=Sa8
    logic [3:0][7:0]          rx_acc_d;   // gathered bits including this cycle
    logic [3:0][7:0]          rx_q;       // host-visible captures
    e1sa_pkg::e1sa_txset_type tx_regs_q;  // host-written transmit registers
    e1sa_pkg::e1sa_txset_type txset_q;    // copy in use for this multiframe
    logic [7:0]               ctrl_q;     // insertion control
    e1sa_pkg::e1sa_ovh_type   ovh_d;      // next overhead bits
    logic [7:0]               rdata_d;    // read mux
    logic                     mapped;     // address hits a register
    logic [2:0]               rx_slot;    // bit slot of current rx frame

    // ************************************************************
    // receive capture
    // ************************************************************

    // place each odd-frame Sa bit at its slot, earliest in the MSB
    always_comb begin
        rx_slot  = e1sa_pkg::e1sa_frame_bit(rx_frame_i);
        rx_acc_d = rx_acc_q;
        if (rx_odd_strobe_i && rx_frame_i[0]) begin
            for (int i = 0; i <= 3; i++) begin
                rx_acc_d[i][rx_slot] = rx_sa_i[i];
            end
        end
    end

    // gatherer; even-frame strobes are ignored
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rx_acc_q <= '0;
        end else if (ce_i) begin
            rx_acc_q <= rx_acc_d;
        end
    end

    // copy at the flag; a bit in the same cycle still lands
    // host must read within one multiframe or the data is replaced
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rx_q <= {4{e1sa_pkg::E1SA_REG_RESET}};
        end else if (ce_i && rx_multiframe_flag_i) begin
            rx_q <= rx_acc_d;
        end
    end

    // ************************************************************
    // host register port
    // ************************************************************

    // transmit registers and control; read-only offsets drop writes
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tx_regs_q <= {8{e1sa_pkg::E1SA_REG_RESET}};
            ctrl_q    <= e1sa_pkg::E1SA_REG_RESET;
        end else if (ce_i && wr_i) begin
            unique case (addr_i)
                e1sa_pkg::E1SA_TX_SI_AL_OFS:  tx_regs_q.si_align    <= wdata_i;
                e1sa_pkg::E1SA_TX_SI_NAL_OFS: tx_regs_q.si_nonalign <= wdata_i;
                e1sa_pkg::E1SA_TX_RA_OFS:     tx_regs_q.ra          <= wdata_i;
                e1sa_pkg::E1SA_TX_CTRL_OFS:   ctrl_q                <= wdata_i;
                default: begin
                    // Sa4..Sa8 sit on consecutive offsets
                    if (addr_i >= e1sa_pkg::E1SA_TX_SPARE4_OFS &&
                        addr_i <= e1sa_pkg::E1SA_TX_SPARE8_OFS) begin
                        tx_regs_q.sa[3'(e1sa_pkg::E1SA_TX_SPARE8_OFS - addr_i)] <= wdata_i;
                    end
                end
            endcase
        end
    end

    // read decode
    always_comb begin
        mapped  = 1'b1;
        rdata_d = e1sa_pkg::E1SA_READ_NONE;
        unique case (addr_i)
            e1sa_pkg::E1SA_RX_SPARE5_OFS: rdata_d = rx_q[3];
            e1sa_pkg::E1SA_RX_SPARE6_OFS: rdata_d = rx_q[2];
            e1sa_pkg::E1SA_RX_SPARE7_OFS: rdata_d = rx_q[1];
            e1sa_pkg::E1SA_RX_SPARE8_OFS: rdata_d = rx_q[0];
            e1sa_pkg::E1SA_TX_SI_AL_OFS:  rdata_d = tx_regs_q.si_align;
            e1sa_pkg::E1SA_TX_SI_NAL_OFS: rdata_d = tx_regs_q.si_nonalign;
            e1sa_pkg::E1SA_TX_RA_OFS:     rdata_d = tx_regs_q.ra;
            e1sa_pkg::E1SA_TX_CTRL_OFS:   rdata_d = ctrl_q;
            default: begin
                if (addr_i >= e1sa_pkg::E1SA_TX_SPARE4_OFS &&
                    addr_i <= e1sa_pkg::E1SA_TX_SPARE8_OFS) begin
                    rdata_d = tx_regs_q.sa[3'(e1sa_pkg::E1SA_TX_SPARE8_OFS - addr_i)];
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
    end

    // read data registered; holds until the next read
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_o <= e1sa_pkg::E1SA_REG_RESET;
        end else if (ce_i && rd_i) begin
            rdata_o <= rdata_d;
        end
    end

    // ************************************************************
    // transmit insertion
    // ************************************************************

    // snapshot at the flag so a host write mid-multiframe cannot tear it
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            txset_q <= {8{e1sa_pkg::E1SA_REG_RESET}};
        end else if (ce_i && tx_multiframe_flag_i) begin
            txset_q <= tx_regs_q;
        end
    end

    e1sa_tx_insert u_insert (
        .set_i   (txset_q),
        .ctrl_i  (ctrl_q),
        .frame_i (tx_frame_i),
        .src_i   (tx_src_i),
        .ovh_o   (ovh_d)
    );

    // one registered result per frame strobe; MSB goes out first
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tx_ovh_o       <= '0;
            tx_ovh_valid_o <= 1'b0;
        end else if (ce_i) begin
            tx_ovh_valid_o <= tx_frame_strobe_i;
            if (tx_frame_strobe_i) begin
                tx_ovh_o <= ovh_d;
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    logic [2:0] tx_slot;  // slot of current tx frame
    logic       exp_si;   // expected Si for current tx frame
    assign tx_slot = e1sa_pkg::e1sa_frame_bit(tx_frame_i);
    assign exp_si  = tx_frame_i[0] ? txset_q.si_nonalign[tx_slot] : txset_q.si_align[tx_slot];

    chk_rx_capture: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && rx_multiframe_flag_i && !rx_odd_strobe_i |=> rx_q == $past(rx_acc_q))
        else $error("rx capture does not match gathered bits");
    chk_rx_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        !(ce_i && rx_multiframe_flag_i) |=> $stable(rx_q))
        else $error("rx capture changed without flag");
    chk_tx_sample: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && tx_multiframe_flag_i |=> txset_q == $past(tx_regs_q))
        else $error("tx set not sampled at flag");
    chk_tx_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        !(ce_i && tx_multiframe_flag_i) |=> $stable(txset_q))
        else $error("tx set changed between flags");
    chk_si_align: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && tx_frame_strobe_i && !tx_frame_i[0] && ctrl_q[7]
        |=> tx_ovh_o.si == $past(exp_si))
        else $error("align Si not inserted");
    chk_si_nonalign: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && tx_frame_strobe_i && tx_frame_i[0] && ctrl_q[6]
        |=> tx_ovh_o.si == $past(exp_si))
        else $error("nonalign Si not inserted");
    chk_ra_insert: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && tx_frame_strobe_i && tx_frame_i[0] && ctrl_q[5] && tx_frame_i[3:1] == 3'h0
        |=> tx_ovh_o.a == $past(txset_q.ra[7]))
        else $error("frame 1 A bit not from register MSB");
    chk_pass_thru: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && tx_frame_strobe_i && ctrl_q == 8'h00 |=> tx_ovh_o == $past(tx_src_i))
        else $error("disabled insertion altered overhead");
    chk_valid_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i |=> tx_ovh_valid_o == $past(tx_frame_strobe_i))
        else $error("overhead valid does not follow strobe");
    chk_read_none: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && rd_i && !mapped |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    // Sa4 is bit 4, the top bit of the Sa control field, so it checks only that end of the field's bit order
    chk_sa4_insert: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && tx_frame_strobe_i && tx_frame_i[0] && ctrl_q[e1sa_pkg::E1SA_CTRL_SA_MSB]
        |=> tx_ovh_o.sa[4] == $past(txset_q.sa[4][tx_slot]))
        else $error("Sa4 not inserted");
    // align frames carry the sync word there, so A/Sa must never be touched
    chk_even_pass: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && tx_frame_strobe_i && !tx_frame_i[0]
        |=> {tx_ovh_o.a, tx_ovh_o.sa} == $past({tx_src_i.a, tx_src_i.sa}))
        else $error("even frame A or Sa altered");
endmodule

/* hdl/e1sa_tx_insert.sv */
`timescale 1ns/10ps
// ****************************************************************
// per-frame overhead insertion mux
// ****************************************************************
module e1sa_tx_insert (
    input  wire e1sa_pkg::e1sa_txset_type set_i,
    input  wire logic [7:0]               ctrl_i,
    input  wire logic [3:0]               frame_i,
    input  wire e1sa_pkg::e1sa_ovh_type   src_i,
    output e1sa_pkg::e1sa_ovh_type        ovh_o
);
    logic [2:0] slot;  // register bit for this frame

    // combinational; the caller registers the result
    always_comb begin
        slot  = e1sa_pkg::e1sa_frame_bit(frame_i);
        ovh_o = src_i;  // untouched positions keep the framer value
        if (!frame_i[0]) begin
            // align frames carry only Si; A/Sa slots hold the sync word
            if (ctrl_i[e1sa_pkg::E1SA_CTRL_INSERT_INTL_ALIGN_ENABLE]) begin
                ovh_o.si = set_i.si_align[slot];
            end
        end else begin
            if (ctrl_i[e1sa_pkg::E1SA_CTRL_INSERT_INTL_NONALIGN_ENABLE]) begin
                ovh_o.si = set_i.si_nonalign[slot];
            end
            if (ctrl_i[e1sa_pkg::E1SA_CTRL_RA_BIT]) begin
                ovh_o.a = set_i.ra[slot];
            end
            for (int i = 0; i <= int'(e1sa_pkg::E1SA_CTRL_SA_MSB); i++) begin
                if (ctrl_i[i]) begin
                    ovh_o.sa[i] = set_i.sa[i][slot];
                end
            end
        end
    end
endmodule

/* test/e1sa_far_end.sv */
`timescale 1ns/10ps
// ****************************************************************
// remote terminal: sends one multiframe of received Sa5..Sa8 bits
// ****************************************************************
module e1sa_far_end (
    input  wire logic        clk_i,
    input  wire logic        go_i,     // start one multiframe
    input  wire logic [31:0] bits_i,   // nibble per odd frame, frame 1 on top
    output logic             flag_o,   // multiframe flag pulse
    output logic             strobe_o, // frame strobe
    output logic [3:0]       frame_o,  // frame number
    output logic [3:0]       sa_o      // Sa5..Sa8 of that frame
);
    // one process owns every output; frames go out in line order,
    // so bit 7 must be the earliest frame
    initial begin
        flag_o = 1'b0;
        strobe_o = 1'b0;
        frame_o = 4'h0;
        sa_o = 4'h0;
        forever begin
            @(posedge clk_i iff go_i);
            for (int f = 0; f < 16; f++) begin
                #1;
                strobe_o = 1'b1;
                frame_o = 4'(f);
                // even frames carry junk; the bank has to ignore them
                sa_o = f[0] ? bits_i[33 - 2 * f -: 4] : ~sa_o;
                @(posedge clk_i);
            end
            #1;
            strobe_o = 1'b0;
            sa_o = ~sa_o; // released line does not keep its last value
            flag_o = 1'b1;
            @(posedge clk_i);
            #1;
            flag_o = 1'b0;
        end
    end
endmodule

/* test/testbench.sv */
`timescale 1ns/10ps
// ****************************************************************
// self-checking bench for the multiframe Si/A/Sa register bank
// ****************************************************************
module testbench;
    logic                   clk, reset, ce, wr, rd, go;
    logic [7:0]             addr, wdata, rdata;
    logic                   rx_flag, rx_stb, tx_flag, tx_stb, tx_valid;
    logic [3:0]             rx_frame, rx_sa, tx_frame;
    logic [31:0]            rx_bits;
    e1sa_pkg::e1sa_ovh_type tx_src, tx_ovh, exp_ovh;
    logic [7:0]             v [8];  // transmit set, index 0 is offset D2
    int                     miscompares, checks_done, cycles;

    always #50 clk = ~clk;

    e1sa_regs dut (.clk_i(clk), .reset_i(reset), .ce_i(ce), .addr_i(addr), .wr_i(wr),
        .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata), .rx_multiframe_flag_i(rx_flag),
        .rx_odd_strobe_i(rx_stb), .rx_frame_i(rx_frame), .rx_sa_i(rx_sa),
        .tx_multiframe_flag_i(tx_flag), .tx_frame_strobe_i(tx_stb), .tx_frame_i(tx_frame),
        .tx_src_i(tx_src), .tx_ovh_o(tx_ovh), .tx_ovh_valid_o(tx_valid));

    e1sa_far_end far (.clk_i(clk), .go_i(go), .bits_i(rx_bits), .flag_o(rx_flag),
        .strobe_o(rx_stb), .frame_o(rx_frame), .sa_o(rx_sa));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk_byte(string n, logic [7:0] e, logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    // idle cycle after each access keeps strobes from toggling twice in one step
    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        addr = a; wdata = d; wr = 1'b1;
        @(posedge clk); #1;
        wr = 1'b0;
        @(posedge clk); #1;
    endtask

    task automatic rd_chk(string n, logic [7:0] a, logic [7:0] e);
        addr = a; rd = 1'b1;
        @(posedge clk); #1;
        rd = 0;
        chk_byte(n, e, rdata);
        @(posedge clk); #1;
    endtask

    // expected overhead of frame f under control c
    function automatic e1sa_pkg::e1sa_ovh_type want(int f, logic [7:0] c);
        int b = 7 - f / 2;
        want = tx_src;
        if (f % 2 == 0) begin
            if (c[7]) want.si = v[0][b];
        end else begin
            if (c[6]) want.si = v[1][b];
            if (c[5]) want.a = v[2][b];
            for (int i = 0; i < 5; i++)
                if (c[i]) want.sa[i] = v[7 - i][b];
        end
    endfunction

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic reg_test();
        logic [7:0] a;
        for (int i = 0; i < 16; i++) begin
            a = 8'hCC + 8'(i);
            rd_chk("reset value", a, 8'h00);
            wr_reg(a, a ^ 8'h5A);
        end
        // only D2..DA take writes; receive and unmapped places read zero
        for (int i = 0; i < 16; i++) begin
            a = 8'hCC + 8'(i);
            rd_chk("read back", a, (a >= 8'hD2 && a <= 8'hDA) ? a ^ 8'h5A : 8'h00);
        end
    endtask

    task automatic rx_test();
        logic [7:0] s [4] = '{8'h96, 8'h3C, 8'hE1, 8'h5A};
        for (int k = 0; k < 8; k++)
            rx_bits[31 - 4 * k -: 4] = {s[0][7 - k], s[1][7 - k], s[2][7 - k], s[3][7 - k]};
        go = 1'b1;
        @(posedge clk); #1;
        go = 1'b0;
        for (int i = 0; i < 40 && rx_flag !== 1'b1; i++) @(posedge clk);
        #1;
        for (int k = 0; k < 4; k++)
            rd_chk("rx spare", 8'hCC + 8'(k), s[k]);
    endtask

    task automatic tx_run(logic [7:0] ctrl, logic [7:0] seed);
        for (int k = 0; k < 8; k++) begin
            v[k] = seed + 8'(k * 37);
            wr_reg(8'hD2 + 8'(k), v[k]);
        end
        wr_reg(8'hDA, ctrl);
        tx_flag = 1'b1;
        @(posedge clk); #1;
        tx_flag = 1'b0;
        // late writes must wait for the next flag
        for (int k = 0; k < 8; k++) wr_reg(8'hD2 + 8'(k), ~v[k]);
        tx_stb = 1'b1;
        for (int f = 0; f < 16; f++) begin
            tx_frame = 4'(f);
            tx_src = 7'(f * 11 + 5);
            exp_ovh = want(f, ctrl);
            @(posedge clk); #1;
            chk_byte("tx frame", {1'b1, exp_ovh}, {tx_valid, tx_ovh});
        end
        tx_stb = 1'b0;
        @(posedge clk); #1;
        chk_byte("tx idle", {1'b0, exp_ovh}, {tx_valid, tx_ovh});
    endtask

    // frozen enable drops a write and a strobe; a short reset clears the bank
    task automatic ce_test();
        ce = 1'b0;
        wr_reg(8'hD2, 8'hC3);
        tx_stb = 1'b1;
        @(posedge clk); #1;
        tx_stb = 1'b0;
        chk_byte("frozen output", {1'b0, exp_ovh}, {tx_valid, tx_ovh});
        ce = 1'b1;
        rd_chk("frozen write", 8'hD2, ~v[0]);
        reset = 1'b1;
        @(posedge clk); #1;
        reset = 1'b0;
        rd_chk("reset clears", 8'hD2, 8'h00);
    endtask

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            end_sim();
        end
    end

    initial begin
        clk = 0; reset = 1; ce = 1; wr = 0; rd = 0; go = 0;
        addr = 8'h00; wdata = 8'h00; rx_bits = 32'h0;
        tx_flag = 0; tx_stb = 0; tx_frame = 4'h0; tx_src = '0;
        repeat (10) @(posedge clk);
        #1 reset = 0;
        reg_test();
        rx_test();
        tx_run(8'hA5, 8'h31);
        tx_run(8'h5A, 8'hC4);
        tx_run(8'h00, 8'h7E);
        ce_test();
        end_sim();
    end
endmodule
